// ===== serial_shifter_map.vh
// register map and field layout of the soft-clocked serial shifter
`ifndef SERIAL_SHIFTER_MAP_VH
`define SERIAL_SHIFTER_MAP_VH

// register indices; byte address is four times the index
`define IDX_SERIAL_IRQ_DISABLE_STROBE 12'h0c2
`define IDX_SERIAL_SHIFT_DATA         12'h0dd
`define IDX_PORT_CTRL                 12'h0de
`define IDX_LINE_STATUS               12'h0df

`define ADDR_WIDTH                    12
`define ADDR_SERIAL_IRQ_DISABLE_STROBE 12'h308
`define ADDR_SERIAL_SHIFT_DATA        12'h374
`define ADDR_PORT_CTRL                12'h378
`define ADDR_LINE_STATUS              12'h37c

// port control fields
`define PCTL_SCL_LEVEL                0
`define PCTL_SCL_PUSH_PULL            1
`define PCTL_SCL_OPEN_DRAIN           2
`define PCTL_SIN_PULL_LOW             3
`define PCTL_SOUT_OPEN_DRAIN          4
`define PCTL_WIDTH                    5
`define PCTL_RESET                    5'h01

// line status fields
`define STAT_SIN                      0
`define STAT_SCL                      1
`define STAT_CHIP_EN                  2
`define STAT_COUNT_DONE_OUTPUT        3
`define STAT_COUNT_LSB                4
`define STAT_COUNT_MSB                7

// reset values, and the read bit of the interrupt enable
`define SHIFT_RESET                   8'h00
`define COUNT_RESET                   4'h0
`define IRQ_DISABLE_READ_EN_BIT       0

`endif

// ===== soft_clocked_serial_shifter.v
// soft-clocked serial shifter with apb register access
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
// Overview of operation
// - 8-bit shift register plus 4-bit counter of serial clock pulses.
// - bytes leave most significant bit first on the serial output.
// - shift register and counter advance on falling serial clock edges.
// - slave mode: clock pin is input, external party supplies pulses.
// - master mode: clock pin output, software toggles its port bit.
// - after eight pulses counter top bit goes high and stops clocking.
// - interrupt on eighth falling edge unless a data write resets first.
// - interrupt off after reset, on by data write, off by disable write.
// - interrupt request is a high-to-low transition.
// - reset or data write clears counter and re-enables clocking.
// - bits are accepted on clock pulses with no start condition.
// - interrupt means byte received or transmission finished.
// - software can pull data input low and hold clock for ack.
// - data input stays input; output is open-drain when used.
// - open-drain output mode connects shift register msb to the pin.
// - slave software stretches clock with open-drain low on clock pin.
// - start via data line port watch; stop found by polling lines.
// - data and clock pin levels are readable through the port.
// - a general pin acts as chip enable; tie data lines for three-wire.
// - leave interrupt disabled when unused; dummy write disables it.
`include "serial_shifter_map.vh"

module soft_clocked_serial_shifter #(
	parameter DATA_WIDTH  = 8,
	parameter COUNT_WIDTH = 4
) (
	input  wire                   clk_i,
	input  wire                   reset_i,
	input  wire                   ce_i,
	// apb slave
	input  wire                   psel_i,
	input  wire                   penable_i,
	input  wire                   pwrite_i,
	input  wire [`ADDR_WIDTH-1:0] paddr_i,
	input  wire [31:0]            pwdata_i,
	output wire [31:0]            prdata_o,
	output wire                   pready_o,
	output wire                   pslverr_o,
	// serial clock pin
	input  wire                   scl_i,
	output wire                   scl_o,
	output wire                   scl_oe_o,
	// serial data input pin
	input  wire                   sin_i,
	output wire                   sin_o,
	output wire                   sin_oe_o,
	// serial data output pin, open-drain
	output wire                   sout_o,
	output wire                   sout_oe_o,
	// general pin used as chip enable
	input  wire                   chip_en_i,
	// interrupt request, falling edge
	output wire                   irq_n_o
);

	// synchronised pin levels, taken from the second stage
	wire                   scl_sync_r;
	wire                   sin_sync_r;
	wire                   cs_sync_r;
	reg                    scl_prev_r;

	// shifter state
	reg  [DATA_WIDTH-1:0]  shift_r;
	reg  [DATA_WIDTH-1:0]  shift_nxt;
	reg  [COUNT_WIDTH-1:0] count_r;
	reg  [COUNT_WIDTH-1:0] count_nxt;
	reg                    irq_en_r;
	reg                    irq_en_nxt;
	reg                    irq_n_r;
	reg                    irq_n_nxt;

	// port control and pin drivers
	reg  [`PCTL_WIDTH-1:0] pctl_r;
	reg                    scl_oe_r;
	reg                    scl_out_r;
	reg                    sin_oe_r;
	reg                    sout_oe_r;
	reg                    scl_oe_nxt;
	reg                    scl_out_nxt;
	reg                    sin_oe_nxt;
	reg                    sout_oe_nxt;

	// apb answer
	reg  [31:0]            prdata_r;
	reg                    pready_r;
	reg                    pslverr_r;
	reg  [31:0]            prdata_nxt;
	reg                    pready_nxt;
	reg                    pslverr_nxt;

	wire                   count_done_output;
	wire                   scl_fall;
	wire                   shift_edge;
	wire                   last_edge;
	wire                   apb_access;
	wire                   apb_done;
	wire                   wr_shift;
	wire                   wr_disable;
	wire                   wr_pctl;
	reg  [31:0]            rdata_nxt;
	reg                    addr_hit;

	// top counter bit high marks eight pulses taken
	assign count_done_output = ~count_r[COUNT_WIDTH-1];
	assign scl_fall          = scl_prev_r & ~scl_sync_r;
	assign shift_edge        = scl_fall & count_done_output;
	assign last_edge         = shift_edge &
		(count_r == {1'b0, {(COUNT_WIDTH-1){1'b1}}});

	// apb: one wait state, request taken when pready is seen high
	assign apb_access = psel_i & penable_i;
	assign apb_done   = apb_access & pready_r;
	assign wr_shift   = apb_done & pwrite_i &
		(paddr_i == `ADDR_SERIAL_SHIFT_DATA);
	assign wr_disable = apb_done & pwrite_i &
		(paddr_i == `ADDR_SERIAL_IRQ_DISABLE_STROBE);
	assign wr_pctl    = apb_done & pwrite_i &
		(paddr_i == `ADDR_PORT_CTRL);

	// pins are asynchronous to clk_i; second stage alone feeds logic
	// released lines idle high, so syncs reset high: no false edge
	serial_pin_sync #(
		.RESET_LEVEL (1'b1)
	) u_scl_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.pin_i   (scl_i),
		.sync_o  (scl_sync_r)
	);

	serial_pin_sync #(
		.RESET_LEVEL (1'b1)
	) u_sin_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.pin_i   (sin_i),
		.sync_o  (sin_sync_r)
	);

	serial_pin_sync #(
		.RESET_LEVEL (1'b1)
	) u_cs_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.pin_i   (chip_en_i),
		.sync_o  (cs_sync_r)
	);

	// edge detector history, same reset level as the idle pin
	// limitation: clock levels under one clk period can be missed
	always @(posedge clk_i) begin
		if (reset_i) begin
			scl_prev_r <= 1'b1;
		end else if (ce_i) begin
			scl_prev_r <= scl_sync_r;
		end
	end

	// shifter and interrupt next state
	always @* begin
		shift_nxt  = shift_r;
		count_nxt  = count_r;
		irq_en_nxt = irq_en_r;
		irq_n_nxt  = irq_n_r;
		if (wr_shift) begin
			// data write beats a coincident clock edge
			shift_nxt  = pwdata_i[DATA_WIDTH-1:0];
			count_nxt  = `COUNT_RESET;
			irq_en_nxt = 1'b1;
			irq_n_nxt  = 1'b1;
		end else if (shift_edge) begin
			// no start condition: any enabled falling edge shifts
			shift_nxt = {shift_r[DATA_WIDTH-2:0], sin_sync_r};
			count_nxt = count_r + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
			if (last_edge && irq_en_r) begin
				// byte in or byte out, same event
				irq_n_nxt = 1'b0;
			end
		end
		if (wr_disable) begin
			irq_en_nxt = 1'b0;
			irq_n_nxt  = 1'b1;
		end
	end

	always @(posedge clk_i) begin
		if (reset_i) begin
			shift_r  <= `SHIFT_RESET;
			count_r  <= `COUNT_RESET;
			irq_en_r <= 1'b0;
			irq_n_r  <= 1'b1;
		end else if (ce_i) begin
			shift_r  <= shift_nxt;
			count_r  <= count_nxt;
			irq_en_r <= irq_en_nxt;
			irq_n_r  <= irq_n_nxt;
		end
	end

	// port control register
	always @(posedge clk_i) begin
		if (reset_i) begin
			pctl_r <= `PCTL_RESET;
		end else if (ce_i && wr_pctl) begin
			pctl_r <= pwdata_i[`PCTL_WIDTH-1:0];
		end
	end

	// pin driver next state
	always @* begin
		// master drives its own clock level from the port bit
		scl_out_nxt = pctl_r[`PCTL_SCL_LEVEL];
		// open-drain low holds the clock for stretching
		scl_oe_nxt  = pctl_r[`PCTL_SCL_PUSH_PULL] |
			(pctl_r[`PCTL_SCL_OPEN_DRAIN] &
			~pctl_r[`PCTL_SCL_LEVEL]);
		// data input only ever pulled low, for acknowledge
		sin_oe_nxt  = pctl_r[`PCTL_SIN_PULL_LOW];
		// open-drain mode hands the pin to the shifter msb,
		// so it cannot be used as plain open-drain io
		sout_oe_nxt = pctl_r[`PCTL_SOUT_OPEN_DRAIN] &
			~shift_nxt[DATA_WIDTH-1];
	end

	// pin drivers, registered so outputs come from flops
	always @(posedge clk_i) begin
		if (reset_i) begin
			scl_oe_r  <= 1'b0;
			scl_out_r <= 1'b1;
			sin_oe_r  <= 1'b0;
			sout_oe_r <= 1'b0;
		end else if (ce_i) begin
			scl_oe_r  <= scl_oe_nxt;
			scl_out_r <= scl_out_nxt;
			sin_oe_r  <= sin_oe_nxt;
			sout_oe_r <= sout_oe_nxt;
		end
	end

	assign scl_o     = scl_out_r;
	assign scl_oe_o  = scl_oe_r;
	assign sin_o     = 1'b0;
	assign sin_oe_o  = sin_oe_r;
	assign sout_o    = 1'b0;
	assign sout_oe_o = sout_oe_r;
	assign irq_n_o   = irq_n_r;

	// read mux
	always @* begin
		rdata_nxt = 32'h0000_0000;
		addr_hit  = 1'b1;
		case (paddr_i)
		`ADDR_SERIAL_SHIFT_DATA: begin
			rdata_nxt[DATA_WIDTH-1:0] = shift_r;
		end
		`ADDR_SERIAL_IRQ_DISABLE_STROBE: begin
			rdata_nxt[`IRQ_DISABLE_READ_EN_BIT] = irq_en_r;
		end
		`ADDR_PORT_CTRL: begin
			rdata_nxt[`PCTL_WIDTH-1:0] = pctl_r;
		end
		`ADDR_LINE_STATUS: begin
			// live pin levels let software check start, stop,
			// chip enable and arbitration mismatches
			rdata_nxt[`STAT_SIN]     = sin_sync_r;
			rdata_nxt[`STAT_SCL]     = scl_sync_r;
			rdata_nxt[`STAT_CHIP_EN] = cs_sync_r;
			rdata_nxt[`STAT_COUNT_DONE_OUTPUT] = count_done_output;
			rdata_nxt[`STAT_COUNT_MSB:`STAT_COUNT_LSB] = count_r;
		end
		default: begin
			addr_hit = 1'b0;
		end
		endcase
	end

	// one wait state keeps prdata registered at the answer edge
	always @* begin
		pready_nxt  = 1'b0;
		prdata_nxt  = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		if (apb_access && !pready_r) begin
			// unmapped offsets answer with an error and no effect
			pready_nxt  = 1'b1;
			prdata_nxt  = pwrite_i ? 32'h0000_0000 : rdata_nxt;
			pslverr_nxt = ~addr_hit;
		end
	end

	// ce low stretches the wait state as well
	always @(posedge clk_i) begin
		if (reset_i) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (ce_i) begin
			pready_r  <= pready_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata_o  = prdata_r;
	assign pready_o  = pready_r;
	assign pslverr_o = pslverr_r;

endmodule // soft_clocked_serial_shifter

// two-flop synchroniser for one asynchronous pin
module serial_pin_sync #(
	parameter RESET_LEVEL = 1'b1
) (
	input  wire clk_i,
	input  wire reset_i,
	input  wire ce_i,
	input  wire pin_i,
	output wire sync_o
);

	reg         meta_r;
	reg         sync_r;

	// reset level should match the idle level of the pin
	// only the second stage leaves this module
	always @(posedge clk_i) begin
		if (reset_i) begin
			meta_r <= RESET_LEVEL;
			sync_r <= RESET_LEVEL;
		end else if (ce_i) begin
			meta_r <= pin_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;

endmodule // serial_pin_sync

// ===== soft_clocked_serial_shifter_asserts.sv
// port-level assertion checker for the serial shifter
`timescale 1ns/10ps
module soft_clocked_serial_shifter_asserts (
	input wire        clk_i, reset_i, psel_i, penable_i, pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] prdata_o,
	input wire        pready_o, pslverr_o, sout_o, sin_o, irq_n_o
);
	wire wr = pready_o && pwrite_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_ready_wait: assert property (psel_i && penable_i && !pready_o
		&& $past(psel_i && !penable_i) |=> pready_o) else $error("no ready");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready too long");
	a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside answer");
	a_byte_wide: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_err_unmap: assert property (pready_o && !(paddr_i inside
		{12'h308, 12'h374, 12'h378, 12'h37c}) |-> pslverr_o)
		else $error("unmapped address accepted");
	a_irq_reset: assert property (disable iff (1'b0) reset_i |=> irq_n_o)
		else $error("irq active after reset");
	a_irq_rearm: assert property (wr && paddr_i == 12'h374 |=> irq_n_o)
		else $error("irq low after data write");
	a_irq_off: assert property (wr && paddr_i == 12'h308 |=> irq_n_o[*2])
		else $error("irq low after disable write");
	a_irq_hold: assert property (!irq_n_o && !wr |=> !irq_n_o)
		else $error("irq released without write");
	a_pins_low: assert property (sout_o == 1'b0 && sin_o == 1'b0)
		else $error("open-drain pin driven high");
	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
endmodule // soft_clocked_serial_shifter_asserts
bind soft_clocked_serial_shifter soft_clocked_serial_shifter_asserts u_chk (
	.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.sout_o(sout_o), .sin_o(sin_o), .irq_n_o(irq_n_o));

// ===== serial_master_model.sv
// external serial master clocking the shifter link
`timescale 1ns/10ps
module serial_master_model (
	input  wire sout_i,
	output reg  scl_o,
	output reg  sin_o
);
	// clock stands high between frames
	initial begin
		scl_o = 1'b1;
		sin_o = 1'b1;
	end
	task automatic xfer(input int n, input [7:0] tx, output [7:0] rx);
		rx = 8'h00;
		// keep link edges away from clk edges
		#10;
		for (int i = 7; i > 7 - n; i--) begin
			sin_o = tx[i];
			#80 rx[i] = sout_i;
			#80 scl_o = 1'b0;
			#160 scl_o = 1'b1;
		end
		// released line goes to its pull-up level
		sin_o = 1'b1;
	endtask
endmodule // serial_master_model

// ===== soft_clocked_serial_shifter_tb.sv
// self-checking bench for the soft-clocked serial shifter
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin \
	fail_count++; $display("Error %s exp %h got %h", n, e, s); end end
module soft_clocked_serial_shifter_tb;
	reg         clk_i = 0, reset_i = 1, ce_i = 1, chip_en_i = 0;
	reg         psel_i = 0, penable_i = 0, pwrite_i = 0;
	reg  [11:0] paddr_i = 0;
	reg  [31:0] pwdata_i = 0;
	wire [31:0] prdata_o;
	wire        pready_o, pslverr_o, scl_o, scl_oe_o, sin_o, sin_oe_o;
	wire        sout_o, sout_oe_o, irq_n_o, m_scl, m_sin;
	// wired-and lines with pull-ups
	wire        scl_i = m_scl & ~(scl_oe_o & ~scl_o);
	wire        sin_i = m_sin & ~sin_oe_o;
	int         fail_count = 0, tests_run = 0;
	reg  [32:0] expq[$];
	reg  [32:0] ex;
	reg  [7:0]  tx, rxin, got;
	always #20 clk_i = ~clk_i;
	soft_clocked_serial_shifter u_soft_clocked_serial_shifter (
		.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .scl_i(scl_i),
		.scl_o(scl_o), .scl_oe_o(scl_oe_o), .sin_i(sin_i),
		.sin_o(sin_o), .sin_oe_o(sin_oe_o), .sout_o(sout_o),
		.sout_oe_o(sout_oe_o), .chip_en_i(chip_en_i),
		.irq_n_o(irq_n_o));
	serial_master_model u_serial_master_model (.sout_i(~sout_oe_o),
		.scl_o(m_scl), .sin_o(m_sin));
	always @(posedge clk_i) if (pready_o === 1'b1) begin
		ex = expq.pop_front();
		`CHK("apb", ex, {pslverr_o, prdata_o})
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input w, input [11:0] a, input [31:0] d, input [32:0] e);
		int k;
		expq.push_back(e);
		@(posedge clk_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		k = 0;
		do begin @(posedge clk_i); k++; end while (pready_o !== 1'b1 && k < 20);
		if (k == 20) begin fail_count++; print_verdict; end
		psel_i <= 0;
		penable_i <= 0;
	endtask
	task automatic wr(input [11:0] a, input [31:0] d);
		apb(1, a, d, 33'h0);
	endtask
	task automatic rd(input [11:0] a, input [32:0] e);
		apb(0, a, 32'h0, e);
	endtask
	// sample once the edge's updates have landed
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	initial begin
		void'($urandom(96));
		repeat (4) @(posedge clk_i);
		reset_i <= 0;
		rd(12'h374, 33'h0);
		rd(12'h308, 33'h0);
		rd(12'h378, 33'h1);
		rd(12'h300, 33'h1_0000_0000);
		`CHK("irq", 1'b1, irq_n_o)
		$display("test reset done");
		tx = 8'($urandom);
		rxin = 8'($urandom);
		chip_en_i <= 1'($urandom);
		wr(12'h378, 32'h11);
		wr(12'h374, {24'hffffff, tx});
		rd(12'h308, 33'h1);
		u_serial_master_model.xfer(8, rxin, got);
		idle(4);
		`CHK("sout", tx, got)
		`CHK("irq", 1'b0, irq_n_o)
		rd(12'h374, {25'h0, rxin});
		rd(12'h37c, {25'h0, 4'h8, 1'b0, chip_en_i, 1'b1, 1'b1});
		$display("test byte done");
		wr(12'h378, 32'h19);
		idle(1);
		`CHK("ack", 2'b10, {sin_oe_o, sin_i})
		u_serial_master_model.xfer(1, 8'hff, got);
		rd(12'h374, {25'h0, rxin});
		wr(12'h308, 32'h0);
		idle(1);
		`CHK("irq", 1'b1, irq_n_o)
		$display("test ack done");
		wr(12'h378, 32'h11);
		wr(12'h374, 32'h0);
		u_serial_master_model.xfer(4, 8'h00, got);
		idle(4);
		`CHK("irq", 1'b1, irq_n_o)
		wr(12'h374, {24'h0, tx});
		wr(12'h308, 32'h0);
		u_serial_master_model.xfer(8, rxin, got);
		idle(4);
		`CHK("irq", 1'b1, irq_n_o)
		rd(12'h374, {25'h0, rxin});
		$display("test restart done");
		for (int i = 0; i < 2; i++) begin
			wr(12'h378, i ? 32'h4 : 32'h2);
			idle(1);
			`CHK("scl", 2'b10, {scl_oe_o, scl_o})
		end
		$display("test clock drive done");
		idle(2);
		print_verdict;
	end
endmodule // soft_clocked_serial_shifter_tb
